// ---- core/mmd_decoder.sv ----
// Memory map decoder steering core accesses to nonvolatile banks, SRAM and registers.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder #(
  parameter int unsigned SRAM_AW = 11
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_resetn,
  input  wire logic                       i_req,
  input  wire logic                       i_we,
  input  wire logic [1:0]                 i_size,
  input  wire logic [mmd_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [mmd_pkg::DATA_W-1:0] i_wdata,
  output logic                            o_ready,
  output logic      [mmd_pkg::DATA_W-1:0] o_rdata,
  output logic                            o_nv_req,
  output logic                            o_nv_we,
  output logic      [19:0]                o_nv_addr,
  output logic      [mmd_pkg::NV_W-1:0]   o_nv_wdata,
  output logic      [1:0]                 o_nv_be,
  output logic                            o_nv_boot,
  output logic      [7:0]                 o_nv_page,
  input  wire logic [mmd_pkg::NV_W-1:0]   i_nv_rdata,
  output logic                            o_hp_sel,
  output logic                            o_pb_sel,
  output logic                            o_reg_we,
  output logic      [15:0]                o_reg_addr,
  output logic      [3:0]                 o_reg_be,
  output logic      [31:0]                o_reg_wdata,
  input  wire logic [31:0]                i_hp_rdata,
  input  wire logic [31:0]                i_pb_rdata,
  output logic                            o_remap_flash
);
  import mmd_pkg::*;

  typedef struct packed {
    mmd_state_e  st;
    mmd_tgt_e    tgt;
    logic        remap;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ready;
    logic        nv_req;
    logic        nv_we;
    logic [19:0] nv_addr;
    logic [15:0] nv_wdata;
    logic [1:0]  nv_be;
    logic        hp_sel;
    logic        pb_sel;
    logic        nv_boot;
    logic [3:0]  reg_be;
  } mmd_state_s;

  mmd_state_s s_q, s_d;
  logic [3:0]  be;
  logic [31:0] wlane;
  logic [31:0] eff;
  mmd_tgt_e    tgt;
  logic [31:0] sram_rdata;
  logic        sram_en;

  // Lane enables and replicated write data from size and low address bits.
  always_comb begin
    case (i_size)
      SZ_BYTE: begin
        be    = 4'h1 << i_addr[1:0];
        wlane = {4{i_wdata[7:0]}};
      end
      SZ_HALF: begin
        be    = i_addr[1] ? 4'hC : 4'h3;
        wlane = {2{i_wdata[15:0]}};
      end
      default: begin
        be    = 4'hF;
        wlane = i_wdata;
      end
    endcase
  end

  // Address decode; the low alias folds onto the selected memory.
  always_comb begin
    eff = i_addr;
    if (i_addr < ALIAS_END) begin
      eff = s_q.remap ? (NV0_BASE + i_addr) : (SRAM_BASE + i_addr);
    end
    if (eff >= NV0_BASE && eff < NV1_END) begin
      tgt = TG_NV;
    end else if (eff >= SRAM_BASE && eff < SRAM_END) begin
      tgt = TG_SRAM;
    end else if (eff == REMAP_ADDR) begin
      tgt = TG_REMAP;
    end else if ((eff >= HP_GPIO_BASE && eff < HP_GPIO_END) ||
                 (eff >= HP_NVC_BASE && eff < HP_NVC_END)) begin
      tgt = TG_HP;
    end else if (eff >= MRS_BASE) begin
      tgt = TG_PB;
    end else begin
      tgt = TG_NONE;
    end
  end

  assign sram_en = (s_q.st == ST_IDLE) && i_req && (tgt == TG_SRAM);

  mmd_sram #(
    .WORDS (1 << SRAM_AW),
    .AW    (SRAM_AW)
  ) u_sram (
    .i_clk   (i_clk),
    .i_en    (sram_en),
    .i_we    (i_we),
    .i_be    (be),
    .i_addr  (eff[SRAM_AW+1:2]),
    .i_wdata (wlane),
    .o_rdata (sram_rdata)
  );

  always_comb begin
    s_d = s_q;
    s_d.ready   = 1'b0;
    s_d.nv_req  = 1'b0;
    s_d.hp_sel  = 1'b0;
    s_d.pb_sel  = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (i_req) begin
          s_d.tgt   = tgt;
          s_d.we    = i_we;
          s_d.size  = i_size;
          s_d.addr  = eff;
          s_d.wdata = wlane;
          s_d.reg_be = be;
          s_d.rdata = 32'h0000_0000;
          case (tgt)
            TG_NV: begin
              // The array is 16 bits wide, so a word takes two halfword cycles; each array
              // access still gets a whole clock, which keeps the array inside its rate limit.
              s_d.nv_req   = 1'b1;
              s_d.nv_we    = i_we;
              s_d.nv_addr  = {eff[19:2], i_size == SZ_WORD ? 1'b0 : eff[1], 1'b0};
              s_d.nv_wdata = (i_size != SZ_WORD && eff[1]) ? wlane[31:16] : wlane[15:0];
              s_d.nv_be    = (i_size == SZ_WORD) ? 2'h3 : (eff[1] ? be[3:2] : be[1:0]);
              s_d.st       = ST_NV_LO;
            end
            TG_SRAM: begin
              s_d.st      = ST_DONE;
            end
            TG_REMAP: begin
              if (i_we && be[0]) begin
                s_d.remap = wlane[0];
              end
              s_d.rdata = i_we ? 32'h0000_0000 : {31'h0000_0000, s_q.remap};
              s_d.ready = 1'b1;
            end
            TG_HP: begin
              s_d.hp_sel = 1'b1;
              s_d.st     = ST_DONE;
            end
            TG_PB: begin
              s_d.pb_sel = 1'b1;
              s_d.st     = ST_PB_WAIT;
            end
            default: begin
              s_d.ready = 1'b1;
            end
          endcase
        end
      end
      ST_NV_LO: begin
        if (s_q.we) begin
          s_d.rdata = 32'h0000_0000;
        end else if (s_q.addr[1] && s_q.size != SZ_WORD) begin
          s_d.rdata[31:16] = i_nv_rdata;
        end else begin
          s_d.rdata[15:0] = i_nv_rdata;
        end
        if (s_q.size == SZ_WORD) begin
          s_d.nv_req   = 1'b1;
          s_d.nv_addr  = s_q.nv_addr + 20'h00002;
          s_d.nv_wdata = s_q.wdata[31:16];
          s_d.st       = ST_NV_HI;
        end else begin
          s_d.ready = 1'b1;
          s_d.st    = ST_IDLE;
        end
      end
      ST_NV_HI: begin
        s_d.rdata[31:16] = s_q.we ? 16'h0000 : i_nv_rdata;
        s_d.ready        = 1'b1;
        s_d.st           = ST_IDLE;
      end
      ST_PB_WAIT: begin
        s_d.pb_sel = 1'b1;
        s_d.st     = ST_DONE;
      end
      ST_DONE: begin
        case (s_q.tgt)
          TG_SRAM: s_d.rdata = sram_rdata;
          TG_HP:   s_d.rdata = i_hp_rdata;
          TG_PB:   s_d.rdata = i_pb_rdata;
          default: s_d.rdata = 32'h0000_0000;
        endcase
        if (s_q.we) begin
          s_d.rdata = 32'h0000_0000;
        end
        s_d.ready = 1'b1;
        s_d.st    = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.nv_boot = ({12'h000, s_d.nv_addr} >= NV_BOOT_BASE) && ({12'h000, s_d.nv_addr} < NV0_END);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.tgt   <= TG_NONE;
      s_q.remap <= REMAP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ready       = s_q.ready;
  assign o_rdata       = s_q.rdata;
  assign o_nv_req      = s_q.nv_req;
  assign o_nv_we       = s_q.nv_we;
  assign o_nv_addr     = s_q.nv_addr;
  assign o_nv_wdata    = s_q.nv_wdata;
  assign o_nv_be       = s_q.nv_be;
  assign o_nv_boot     = s_q.nv_boot;
  assign o_nv_page     = s_q.nv_addr[16:9];
  assign o_hp_sel      = s_q.hp_sel;
  assign o_pb_sel      = s_q.pb_sel;
  assign o_reg_we      = s_q.we;
  assign o_reg_addr    = s_q.addr[15:0];
  assign o_reg_be      = s_q.reg_be;
  assign o_reg_wdata   = s_q.wdata;
  assign o_remap_flash = s_q.remap;
endmodule : mmd_decoder
`default_nettype wire

// ---- core/mmd_pkg.sv ----
// Constants for the memory map decoder.
package mmd_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NV_W   = 16;
  localparam logic [31:0] NV0_BASE = 32'h0008_0000;
  localparam logic [31:0] NV0_END  = 32'h0009_0000;
  localparam logic [31:0] NV1_BASE = 32'h0009_0000;
  localparam logic [31:0] NV1_END  = 32'h0009_F700;
  localparam logic [31:0] NV_BOOT_HALFWORDS = 32'h0000_0400;
  localparam logic [31:0] NV_BOOT_BASE = NV0_END - (NV_BOOT_HALFWORDS << 1);
  localparam logic [31:0] NV_PAGE_BYTES = 32'h0000_0200;
  localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
  localparam logic [31:0] SRAM_WORDS = 32'h0000_0800;
  localparam logic [31:0] SRAM_END  = SRAM_BASE + (SRAM_WORDS << 2);
  localparam logic [31:0] ALIAS_END = 32'h0001_0000;
  localparam logic [31:0] MRS_BASE  = 32'hFFFF_0000;
  localparam logic [31:0] HP_GPIO_BASE = 32'hFFFF_F400;
  localparam logic [31:0] HP_GPIO_END  = 32'hFFFF_F500;
  localparam logic [31:0] HP_NVC_BASE  = 32'hFFFF_F800;
  localparam logic [31:0] HP_NVC_END   = 32'hFFFF_FF00;
  localparam logic [31:0] REMAP_ADDR   = 32'hFFFF_0220;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic       REMAP_RESET = 1'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_NV_LO = 5'h02,
    ST_NV_HI = 5'h04,
    ST_PB_WAIT = 5'h08,
    ST_DONE = 5'h10
  } mmd_state_e;
  typedef enum logic [2:0] {
    TG_NONE = 3'h0,
    TG_NV = 3'h1,
    TG_SRAM = 3'h2,
    TG_HP = 3'h3,
    TG_PB = 3'h4,
    TG_REMAP = 3'h5
  } mmd_tgt_e;
endpackage : mmd_pkg

// ---- core/mmd_sram.sv ----
// Byte-lane writable word SRAM with registered read data.
`timescale 1ns/1ps
`default_nettype none
module mmd_sram #(
  parameter int unsigned WORDS = 2048,
  parameter int unsigned AW    = 11
) (
  input  wire logic          i_clk,
  input  wire logic          i_en,
  input  wire logic          i_we,
  input  wire logic [3:0]    i_be,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [31:0]   i_wdata,
  output logic      [31:0]   o_rdata
);
  wire logic [31:0] rd_lanes;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      // Each lane owns its storage, so one process alone writes it and narrow writes stay in their lane.
      logic [7:0] mem [WORDS];
      logic [7:0] rd_q;
      always_ff @(posedge i_clk) begin
        if (i_en && i_we && i_be[b]) begin
          mem[i_addr] <= i_wdata[8*b +: 8];
        end
        if (i_en) begin
          rd_q <= mem[i_addr];
        end
      end
      assign rd_lanes[8*b +: 8] = rd_q;
    end
  endgenerate

  assign o_rdata = rd_lanes;
endmodule : mmd_sram
`default_nettype wire

// ---- tb/mmd_decoder_properties.sv ----
// Concurrent checks at the memory map decoder ports.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_chk
  import mmd_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_req,
  input wire logic [1:0]  i_size,
  input wire logic [31:0] i_addr,
  input wire logic        o_ready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_nv_req,
  input wire logic [19:0] o_nv_addr,
  input wire logic        o_nv_boot,
  input wire logic [7:0]  o_nv_page,
  input wire logic        o_hp_sel,
  input wire logic        o_pb_sel,
  input wire logic        o_remap_flash
);
  logic busy_q;
  wire logic take = i_req && !busy_q;
  wire logic nv = i_addr >= NV0_BASE && i_addr < NV1_END;
  wire logic al = i_addr < ALIAS_END;
  wire logic hp = (i_addr >= HP_GPIO_BASE && i_addr < HP_GPIO_END) || (i_addr >= HP_NVC_BASE && i_addr < HP_NVC_END);
  wire logic pb = i_addr >= 32'hFFFF_0300 && i_addr < 32'hFFFF_0900;
  wire logic un = (i_addr >= SRAM_END && i_addr < NV0_BASE) || (i_addr >= NV1_END && i_addr < MRS_BASE);
  // Tracks the access in flight, so a request still held is not taken for a new one.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) busy_q <= 1'b0;
    else busy_q <= take || (busy_q && !o_ready);
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_nv_word_split: assert property (take && nv && i_size == SZ_WORD |=> o_nv_req ##1 o_nv_req ##1 o_ready)
    else $error("word fetch not split in two halves");
  chk_nv_bank_addr: assert property (take && nv |=> o_nv_req && o_nv_addr[19:1] == $past(i_addr[19:1]))
    else $error("bank address wrong");
  chk_alias_flash: assert property (take && al && o_remap_flash |=> o_nv_req && o_nv_addr[19:1] == {4'h8, $past(i_addr[15:1])})
    else $error("zero window not on flash");
  chk_alias_sram: assert property (take && al && !o_remap_flash |=> !o_nv_req ##1 o_ready)
    else $error("zero window not on sram");
  chk_boot_flag: assert property (o_nv_req |-> o_nv_boot == (o_nv_addr >= 20'h8_F800 && o_nv_addr <= 20'h8_FFFE))
    else $error("boot flag wrong");
  chk_page_index: assert property (o_nv_req |-> o_nv_page == 8'((o_nv_addr - 20'h8_0000) >> 9))
    else $error("page index wrong");
  chk_slow_bus_time: assert property (take && pb |=> o_pb_sel [*2] ##1 o_ready)
    else $error("peripheral access not two cycles");
  chk_fast_bus_time: assert property (take && hp |=> o_hp_sel && !o_pb_sel ##1 o_ready)
    else $error("fast access wrong");
  chk_unmapped_zero: assert property (take && un |=> o_ready && o_rdata == 32'h0 && !o_nv_req && !o_pb_sel)
    else $error("unmapped access not ignored");
endmodule : mmd_decoder_chk
bind mmd_decoder mmd_decoder_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req), .i_size(i_size),
  .i_addr(i_addr), .o_ready(o_ready), .o_rdata(o_rdata), .o_nv_req(o_nv_req), .o_nv_addr(o_nv_addr),
  .o_nv_boot(o_nv_boot), .o_nv_page(o_nv_page), .o_hp_sel(o_hp_sel), .o_pb_sel(o_pb_sel),
  .o_remap_flash(o_remap_flash));
`default_nettype wire

// ---- tb/mmd_far_model.sv ----
// Far-side model: halfword array and the two register buses.
`timescale 1ns/1ps
`default_nettype none
module mmd_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_nv_req,
  input  wire logic [19:0] i_nv_addr,
  input  wire logic        i_hp_sel,
  input  wire logic        i_pb_sel,
  input  wire logic [15:0] i_reg_addr,
  output logic      [15:0] o_nv_rdata,
  output logic      [31:0] o_hp_rdata,
  output logic      [31:0] o_pb_rdata
);
  logic [15:0] nv_q;
  logic [31:0] hp_q;
  logic [31:0] pb_q;
  wire logic [15:0] nv_v = i_nv_addr[16:1] ^ 16'h5A3C;
  wire logic [31:0] rg_v = {~i_reg_addr, i_reg_addr};
  // Valid while selected and one cycle after; then the lines toggle every clock,
  // so a late or unselected sample cannot match by chance.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nv_q <= 16'h0;
      hp_q <= 32'h0;
      pb_q <= 32'h0;
    end else begin
      nv_q <= i_nv_req ? nv_v : ~nv_q;
      hp_q <= i_hp_sel ? rg_v : ~hp_q;
      pb_q <= i_pb_sel ? rg_v : ~pb_q;
    end
  end
  assign o_nv_rdata = i_nv_req ? nv_v : nv_q;
  assign o_hp_rdata = i_hp_sel ? rg_v : hp_q;
  assign o_pb_rdata = i_pb_sel ? rg_v : pb_q;
endmodule : mmd_far_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mmd_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        i_clk = 1'b0, i_resetn = 1'b0, i_req = 1'b0, i_we = 1'b0;
  logic [1:0]  i_size = 2'h0, o_nv_be;
  logic [31:0] i_addr = 32'h0, i_wdata = 32'h0, o_rdata, o_reg_wdata, i_hp_rdata, i_pb_rdata, a, d;
  logic [31:0] seed = 32'hB265DFB9;
  logic        o_ready, o_nv_req, o_nv_we, o_nv_boot, o_hp_sel, o_pb_sel, o_reg_we, o_remap_flash;
  logic [19:0] o_nv_addr;
  logic [15:0] o_nv_wdata, i_nv_rdata, o_reg_addr;
  logic [7:0]  o_nv_page;
  logic [3:0]  o_reg_be;
  logic [31:0] nva [4] = '{NV0_BASE, NV_BOOT_BASE, NV1_BASE, NV1_END - 32'h4};
  int          miscompares = 0, total_checks = 0;
  mmd_decoder u_mmd_decoder (.i_clk, .i_resetn, .i_req, .i_we, .i_size, .i_addr, .i_wdata, .o_ready, .o_rdata,
    .o_nv_req, .o_nv_we, .o_nv_addr, .o_nv_wdata, .o_nv_be, .o_nv_boot, .o_nv_page, .i_nv_rdata, .o_hp_sel,
    .o_pb_sel, .o_reg_we, .o_reg_addr, .o_reg_be, .o_reg_wdata, .i_hp_rdata, .i_pb_rdata, .o_remap_flash);
  mmd_far_model u_mmd_far_model (.i_clk, .i_resetn, .i_nv_req(o_nv_req), .i_nv_addr(o_nv_addr),
    .i_hp_sel(o_hp_sel), .i_pb_sel(o_pb_sel), .i_reg_addr(o_reg_addr), .o_nv_rdata(i_nv_rdata),
    .o_hp_rdata(i_hp_rdata), .o_pb_rdata(i_pb_rdata));
  // At 40 MHz every array access gets a whole clock, which stays under the array's rate limit.
  always #12.5 i_clk = ~i_clk;
  function automatic logic [15:0] nvd(input logic [31:0] x);
    return x[16:1] ^ 16'h5A3C;
  endfunction : nvd
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One access, then read data under a mask and the cycle count.
  task automatic xfer(input logic w, input logic [1:0] s, input logic [31:0] ad, dt, m, e, input int lat);
    int n;
    @(posedge i_clk);
    #2;
    {i_req, i_we, i_size, i_addr, i_wdata} = {1'b1, w, s, ad, dt};
    n = 0;
    do begin
      @(posedge i_clk);
      #2;
      n++;
    end while (o_ready !== 1'b1 && n < 20);
    i_req = 1'b0;
    chk(o_rdata & m, e);
    chk(n, lat);
  endtask : xfer
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    #150000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #2;
    i_resetn = 1'b1;
    chk(o_remap_flash, 32'h1);
    xfer(1'h0, SZ_WORD, 32'h4, 32'h0, ALL, {nvd(32'h6), nvd(32'h4)}, 3);
    foreach (nva[i]) xfer(1'h0, SZ_WORD, nva[i], 32'h0, ALL, {nvd(nva[i] + 32'h2), nvd(nva[i])}, 3);
    xfer(1'h0, SZ_HALF, NV0_BASE + 32'h12, 32'h0, 32'hFFFF_0000, {nvd(NV0_BASE + 32'h12), 16'h0000}, 2);
    xfer(1'h0, SZ_HALF, NV0_BASE + 32'h10, 32'h0, 32'h0000_FFFF, {16'h0000, nvd(NV0_BASE + 32'h10)}, 2);
    xfer(1'h0, SZ_BYTE, NV0_BASE + 32'h13, 32'h0, 32'hFF00_0000, {nvd(NV0_BASE + 32'h12), 16'h0000} & 32'hFF00_0000, 2);
    xfer(1'h1, SZ_BYTE, NV1_BASE + 32'h1, 32'h0000_00AB, ALL, 32'h0, 2);
    chk({o_nv_we, o_nv_be, o_nv_wdata}, {13'h0000, 1'h1, 2'h2, 16'hABAB});
    xfer(1'h1, SZ_HALF, NV1_BASE + 32'h2, 32'h0000_CAFE, ALL, 32'h0, 2);
    chk({o_nv_we, o_nv_be, o_nv_wdata}, {13'h0000, 1'h1, 2'h3, 16'hCAFE});
    chk(o_nv_addr, 32'h0009_0002);
    xfer(1'h1, SZ_WORD, SRAM_BASE, 32'h1122_3344, ALL, 32'h0, 2);
    xfer(1'h1, SZ_BYTE, SRAM_BASE + 32'h1, 32'h0000_00AA, ALL, 32'h0, 2);
    xfer(1'h1, SZ_HALF, SRAM_BASE + 32'h2, 32'h0000_BEEF, ALL, 32'h0, 2);
    xfer(1'h0, SZ_WORD, SRAM_BASE, 32'h0, ALL, 32'hBEEF_AA44, 2);
    xfer(1'h0, SZ_WORD, HP_GPIO_BASE + 32'h4, 32'h0, ALL, 32'h0BFB_F404, 2);
    xfer(1'h0, SZ_WORD, HP_NVC_BASE, 32'h0, ALL, 32'h07FF_F800, 2);
    xfer(1'h1, SZ_HALF, HP_GPIO_BASE + 32'h2, 32'h0000_1234, ALL, 32'h0, 2);
    chk({o_reg_we, o_reg_be, o_reg_addr}, {11'h000, 1'h1, 4'hC, 16'hF402});
    chk(o_reg_wdata[31:16], 32'h1234);
    xfer(1'h0, SZ_WORD, 32'hFFFF_0300, 32'h0, ALL, 32'hFCFF_0300, 3);
    xfer(1'h1, SZ_WORD, 32'hFFFF_0500, 32'h5, ALL, 32'h0, 3);
    chk({o_reg_we, o_reg_be, o_reg_addr}, {11'h000, 1'h1, 4'hF, 16'h0500});
    chk(o_reg_wdata, 32'h5);
    xfer(1'h1, SZ_WORD, 32'h0030_0000, 32'h1234_5678, ALL, 32'h0, 1);
    xfer(1'h0, SZ_WORD, 32'h0030_0000, 32'h0, ALL, 32'h0, 1);
    xfer(1'h1, SZ_WORD, REMAP_ADDR, 32'h0, ALL, 32'h0, 1);
    chk(o_remap_flash, 32'h0);
    xfer(1'h0, SZ_WORD, REMAP_ADDR, 32'h0, ALL, 32'h0, 1);
    xfer(1'h0, SZ_WORD, 32'h0, 32'h0, ALL, 32'hBEEF_AA44, 2);
    repeat (16) begin
      seed = lfsr(seed);
      a = SRAM_BASE + {19'h0, seed[12:2], 2'h0};
      d = lfsr(seed);
      xfer(1'h1, SZ_WORD, a, d, ALL, 32'h0, 2);
      xfer(1'h0, SZ_WORD, a, 32'h0, ALL, d, 2);
      seed = lfsr(d);
      a = NV0_BASE + {15'h0, seed[16:2], 2'h0};
      if (a >= NV1_END) a = a - 32'h1000;
      xfer(1'h0, SZ_WORD, a, 32'h0, ALL, {nvd(a + 32'h2), nvd(a)}, 3);
    end
    i_resetn = 1'b0;
    repeat (3) @(posedge i_clk);
    #2;
    i_resetn = 1'b1;
    chk(o_remap_flash, 32'h1);
    xfer(1'h0, SZ_WORD, 32'h8, 32'h0, ALL, {nvd(32'hA), nvd(32'h8)}, 3);
    xfer(1'h0, SZ_WORD, REMAP_ADDR, 32'h0, ALL, 32'h1, 1);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
